// ==== include/srq_defs.svh ====
// constants of the status byte / service request block
`ifndef SRQ_DEFS_SVH
`define SRQ_DEFS_SVH

// ---------------------------------------------------------------
// register geometry
// ---------------------------------------------------------------
`define REG_W            8
`define CMD_CODE_W       4
`define REG_RESET        8'h00

// ---------------------------------------------------------------
// status byte bit positions
// ---------------------------------------------------------------
`define SB_OPER_BIT      7
`define SB_MSS_BIT       6
`define SB_STD_BIT       5
`define SB_MAV_BIT       4

// ---------------------------------------------------------------
// implemented bit masks, unused positions read as zero
// ---------------------------------------------------------------
`define STD_EVENT_USED   8'hb5
`define OPER_EVENT_USED  8'hdf
`define SRE_USED         8'hb0

// ---------------------------------------------------------------
// decimal response text
// ---------------------------------------------------------------
`define ASCII_ZERO       8'h30
`define BCD_W            12

`endif

// ==== include/srq_pkg.sv ====
// types shared by the status byte / service request block
package srq_pkg;

	// ---------------------------------------------------------------
	// parsed command codes from the message parser
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_NONE          = 4'h0,
		CMD_STB_QUERY     = 4'h1,
		CMD_SRE_WRITE     = 4'h2,
		CMD_SRE_QUERY     = 4'h3,
		CMD_STD_EV_QUERY  = 4'h4,
		CMD_STD_EN_WRITE  = 4'h5,
		CMD_STD_EN_QUERY  = 4'h6,
		CMD_OPER_EV_QUERY = 4'h7,
		CMD_OPER_EN_WRITE = 4'h8,
		CMD_OPER_EN_QUERY = 4'h9,
		CMD_OPER_COND_QRY = 4'ha,
		CMD_CLEAR_STATUS  = 4'hb,
		CMD_RO_WRITE      = 4'hc
	} cmd_e;

endpackage

// ==== tb/srq_asserts.sv ====
// concurrent checks on the status byte block ports
`timescale 1ns/1ps
`include "srq_defs.svh"
module srq_asserts (
	input wire logic       CLK_I,
	input wire logic       RST_I,
	input wire logic       CMD_VALID_I,
	input wire logic [3:0] CMD_CODE_I,
	input wire logic       SPOLL_I,
	input wire logic       CMD_IGNORED_O,
	input wire logic       RESP_VALID_O,
	input wire logic [7:0] RESP_VALUE_O,
	input wire logic [7:0] RESP_ONES_O,
	input wire logic       SPOLL_VALID_O,
	input wire logic [7:0] SPOLL_BYTE_O,
	input wire logic [7:0] STATUS_BYTE_O,
	input wire logic [7:0] SERVICE_MASK_O,
	input wire logic       SRQ_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// --------
	// both copies lag one cycle, so they compare with each other directly
	// --------
	chk_mask_unused: assert property ((SERVICE_MASK_O & ~`SRE_USED) == 8'h00)
		else $error("mask holds unused bits");
	chk_mss_and: assert property (STATUS_BYTE_O[6] == |(STATUS_BYTE_O & SERVICE_MASK_O))
		else $error("master summary differs from masked summaries");
	chk_srq_rise: assert property ($rose(STATUS_BYTE_O[6]) |-> SRQ_O)
		else $error("request line missed a master summary edge");
	chk_srq_cause: assert property ($rose(SRQ_O) |-> STATUS_BYTE_O[6])
		else $error("request line rose without master summary");
	chk_poll_clear: assert property (SPOLL_I |=> SRQ_O == $rose(STATUS_BYTE_O[6]))
		else $error("serial poll did not drop the request");
	chk_poll_byte: assert property (SPOLL_I |=> SPOLL_VALID_O && SPOLL_BYTE_O[6] == $past(SRQ_O))
		else $error("poll byte bit 6 not the request flag");
	chk_ro_ignored: assert property (CMD_VALID_I && CMD_CODE_I == 4'hc |=> CMD_IGNORED_O && !RESP_VALID_O)
		else $error("read-only write not ignored");
	chk_mask_hold: assert property ($changed(SERVICE_MASK_O) |-> $past(CMD_VALID_I, 2) && $past(CMD_CODE_I, 2) == 4'h2)
		else $error("mask changed without a mask write");
	chk_ones_digit: assert property (RESP_VALID_O |-> RESP_ONES_O == 8'h30 + RESP_VALUE_O % 8'h0a)
		else $error("ones digit wrong");
	cov_srq: cover property ($rose(SRQ_O));
	cov_poll: cover property (SPOLL_VALID_O && SPOLL_BYTE_O[6]);
	cov_ignored: cover property (CMD_IGNORED_O);
endmodule // srq_asserts

bind status_byte_service_request srq_asserts u_chk (.CLK_I, .RST_I, .CMD_VALID_I, .CMD_CODE_I, .SPOLL_I,
	.CMD_IGNORED_O, .RESP_VALID_O, .RESP_VALUE_O, .RESP_ONES_O, .SPOLL_VALID_O, .SPOLL_BYTE_O, .STATUS_BYTE_O,
	.SERVICE_MASK_O, .SRQ_O);

// ==== tb/srq_bus_ctl_model.sv ====
// bus controller model issuing parsed commands and serial polls
`timescale 1ns/1ps
module srq_bus_ctl_model (
	input  wire logic       clk_i,
	input  wire logic       ack_i,
	input  wire logic [7:0] value_i,
	input  wire logic [7:0] poll_i,
	output logic            valid_o = 1'b0,
	output logic [3:0]      code_o = 4'h0,
	output logic [7:0]      data_o = 8'h00,
	output logic            spoll_o = 1'b0
);
	// --------
	// requests held across one rising edge
	// --------
	// released lines show the inverse so stale data is never trusted
	task automatic send(input logic [3:0] c, input logic [7:0] d, output logic a, output logic [7:0] v);
		@(negedge clk_i);
		valid_o = 1'b1;
		code_o = c;
		data_o = d;
		@(negedge clk_i);
		valid_o = 1'b0;
		code_o = ~c;
		data_o = ~d;
		a = ack_i;
		v = value_i;
	endtask
	task automatic poll(output logic [7:0] b);
		@(negedge clk_i);
		spoll_o = 1'b1;
		@(negedge clk_i);
		spoll_o = 1'b0;
		b = poll_i;
	endtask
endmodule // srq_bus_ctl_model

// ==== tb/status_byte_service_request_tb_top.sv ====
// self-checking bench of the status byte / service request block
`timescale 1ns/1ps
`include "srq_defs.svh"
module status_byte_service_request_tb_top
	import srq_pkg::*;
();
	logic       CLK_I = 1'b0;
	logic       RST_I = 1'b1;
	logic       MAV_I = 1'b0;
	logic [7:0] STD_EVENT_SET_I = 8'h00;
	logic [7:0] OPER_COND_I = 8'h00;
	logic       CMD_VALID_I, SPOLL_I, CMD_IGNORED_O, RESP_VALID_O, SPOLL_VALID_O, SRQ_O, a;
	logic [3:0] CMD_CODE_I;
	logic [7:0] CMD_DATA_I, RESP_VALUE_O, SPOLL_BYTE_O, STATUS_BYTE_O, SERVICE_MASK_O, v, d;
	logic [7:0] RESP_HUNDREDS_O, RESP_TENS_O, RESP_ONES_O;
	logic [1:0] RESP_LEN_O;
	logic [3:0] wc [3] = '{4'h2, 4'h5, 4'h8};
	logic [3:0] qc [3] = '{4'h3, 4'h6, 4'h9};
	integer     seed = 44836;
	int         n_fail = 0;
	int         compares = 0;
	int         cyc = 0;

	status_byte_service_request dut (.CLK_I, .RST_I, .STD_EVENT_SET_I, .OPER_COND_I, .MAV_I, .CMD_VALID_I,
		.CMD_CODE_I, .CMD_DATA_I, .SPOLL_I, .CMD_IGNORED_O, .RESP_VALID_O, .RESP_VALUE_O, .RESP_HUNDREDS_O,
		.RESP_TENS_O, .RESP_ONES_O, .RESP_LEN_O, .SPOLL_VALID_O, .SPOLL_BYTE_O, .STATUS_BYTE_O,
		.SERVICE_MASK_O, .SRQ_O);
	srq_bus_ctl_model ctl (.clk_i(CLK_I), .ack_i(RESP_VALID_O), .value_i(RESP_VALUE_O), .poll_i(SPOLL_BYTE_O),
		.valid_o(CMD_VALID_I), .code_o(CMD_CODE_I), .data_o(CMD_DATA_I), .spoll_o(SPOLL_I));

	always #2.5 CLK_I = ~CLK_I;
	// the whole sequence needs well under a thousand cycles
	always @(posedge CLK_I) begin
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			close_out();
		end
	end
	// --------
	// helpers
	// --------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	function automatic logic [25:0] dec(input logic [7:0] x);
		dec = {8'h30 + x / 8'h64, 8'h30 + x / 8'h0a % 8'h0a, 8'h30 + x % 8'h0a,
			x > 8'h63 ? 2'h3 : x > 8'h09 ? 2'h2 : 2'h1};
	endfunction
	task automatic qry(input logic [3:0] c, input logic [7:0] e);
		logic [25:0] x;
		x = dec(e);
		ctl.send(c, 8'h00, a, v);
		check({7'h00, a}, 8'h01);
		check(v, e);
		check({6'h00, RESP_LEN_O}, {6'h00, x[1:0]});
		check(RESP_ONES_O, x[9:2]);
		if (e > 8'h09) check(RESP_TENS_O, x[17:10]);
		if (e > 8'h63) check(RESP_HUNDREDS_O, x[25:18]);
	endtask
	task automatic pulse(input logic [7:0] s);
		@(negedge CLK_I);
		STD_EVENT_SET_I = s;
		@(negedge CLK_I);
		STD_EVENT_SET_I = 8'h00;
	endtask
	// --------
	// main sequence
	// --------
	initial begin
		repeat (20) @(posedge CLK_I);
		@(negedge CLK_I);
		RST_I = 1'b0;
		check(STATUS_BYTE_O, 8'h00);
		check(SERVICE_MASK_O, 8'h00);
		qry(CMD_STB_QUERY, 8'h00);
		repeat (6) begin
			d = 8'($random(seed));
			ctl.send(CMD_SRE_WRITE, d, a, v);
			qry(CMD_SRE_QUERY, d & `SRE_USED);
			qry(CMD_SRE_QUERY, d & `SRE_USED);
		end
		for (int i = 0; i < 3; i++) begin
			ctl.send(wc[i], 8'hff, a, v);
			qry(qc[i], i == 0 ? `SRE_USED : 8'hff);
			ctl.send(wc[i], 8'h00, a, v);
			qry(qc[i], 8'h00);
		end
		for (int i = 12; i < 16; i++) begin
			ctl.send(4'(i), 8'hff, a, v);
			check({7'h00, CMD_IGNORED_O}, 8'h01);
		end
		check(SERVICE_MASK_O, 8'h00);
		ctl.send(CMD_STD_EN_WRITE, 8'h20, a, v);
		ctl.send(CMD_SRE_WRITE, 8'h20, a, v);
		pulse(8'h20);
		@(negedge CLK_I);
		check(STATUS_BYTE_O, 8'h60);
		check({7'h00, SRQ_O}, 8'h01);
		qry(CMD_STB_QUERY, 8'h60);
		ctl.poll(v);
		check(v, 8'h60);
		check({7'h00, SRQ_O}, 8'h00);
		check(STATUS_BYTE_O, 8'h60);
		qry(CMD_STD_EV_QUERY, 8'h20);
		@(negedge CLK_I);
		check(STATUS_BYTE_O, 8'h00);
		pulse(8'hff);
		qry(CMD_STD_EV_QUERY, `STD_EVENT_USED);
		qry(CMD_STD_EV_QUERY, 8'h00);
		ctl.send(CMD_OPER_EN_WRITE, 8'hff, a, v);
		repeat (4) begin
			@(negedge CLK_I);
			OPER_COND_I = 8'($random(seed));
			qry(CMD_OPER_COND_QRY, OPER_COND_I & `OPER_EVENT_USED);
		end
		@(negedge CLK_I);
		OPER_COND_I = 8'h00;
		@(negedge CLK_I);
		OPER_COND_I = 8'hff;
		repeat (2) @(negedge CLK_I);
		check(STATUS_BYTE_O, 8'h80);
		// request still pending from the second standard event, master summary now low
		ctl.poll(v);
		check(v, 8'hc0);
		ctl.send(CMD_SRE_WRITE, 8'h80, a, v);
		@(negedge CLK_I);
		check({7'h00, SRQ_O}, 8'h01);
		MAV_I = 1'b1;
		@(negedge CLK_I);
		check(STATUS_BYTE_O, 8'hd0);
		MAV_I = 1'b0;
		pulse(8'h01);
		ctl.send(CMD_CLEAR_STATUS, 8'h00, a, v);
		@(negedge CLK_I);
		check(STATUS_BYTE_O, 8'h00);
		qry(CMD_OPER_EV_QUERY, 8'h00);
		qry(CMD_STD_EV_QUERY, 8'h00);
		qry(CMD_OPER_COND_QRY, `OPER_EVENT_USED);
		// a fresh rise on every condition bit latches the whole used set
		@(negedge CLK_I);
		OPER_COND_I = 8'h00;
		@(negedge CLK_I);
		OPER_COND_I = 8'hff;
		qry(CMD_OPER_EV_QUERY, `OPER_EVENT_USED);
		qry(CMD_OPER_EV_QUERY, 8'h00);
		// mid-run reset with live state: status byte, mask, request, enables and standard events must come back empty
		ctl.send(CMD_SRE_WRITE, `SRE_USED, a, v);
		pulse(8'hff);
		@(negedge CLK_I);
		check({7'h00, SRQ_O}, 8'h01);
		RST_I = 1'b1;
		repeat (2) @(negedge CLK_I);
		RST_I = 1'b0;
		check(STATUS_BYTE_O, 8'h00);
		check(SERVICE_MASK_O, 8'h00);
		check({7'h00, SRQ_O}, 8'h00);
		qry(CMD_SRE_QUERY, 8'h00);
		qry(CMD_STD_EN_QUERY, 8'h00);
		qry(CMD_STD_EV_QUERY, 8'h00);
		qry(CMD_OPER_EN_QUERY, 8'h00);
		close_out();
	end
endmodule // status_byte_service_request_tb_top

// ==== verilog/decimal_response.sv ====
// binary to decimal text converter for query answers
`timescale 1ns/1ps
`include "srq_defs.svh"

module decimal_response (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         load_i,
	input  wire logic [7:0]   value_i,
	output logic              valid_o,
	output logic [7:0]        hundreds_o,
	output logic [7:0]        tens_o,
	output logic [7:0]        ones_o,
	output logic [1:0]        len_o
);

	// ---------------------------------------------------------------
	// shift-add-3 conversion
	// ---------------------------------------------------------------
	function automatic logic [11:0] to_bcd(input logic [7:0] bin);
		logic [19:0] acc;
		acc = {12'h000, bin};
		for (int i = 0; i < 8; i++) begin
			if (acc[11:8] > 4'h4)
				acc[11:8] = acc[11:8] + 4'h3;
			if (acc[15:12] > 4'h4)
				acc[15:12] = acc[15:12] + 4'h3;
			if (acc[19:16] > 4'h4)
				acc[19:16] = acc[19:16] + 4'h3;
			acc = acc << 1;
		end
		return acc[19:8];
	endfunction

	wire logic [11:0] bcd = to_bcd(value_i);
	// leading zeros are dropped, zero itself is one digit
	wire logic [1:0]  next_len = (bcd[11:8] != 4'h0) ? 2'h3 : (bcd[7:4] != 4'h0) ? 2'h2 : 2'h1;

	// ---------------------------------------------------------------
	// registered answer
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			valid_o    <= 1'b0;
			hundreds_o <= `ASCII_ZERO;
			tens_o     <= `ASCII_ZERO;
			ones_o     <= `ASCII_ZERO;
			len_o      <= 2'h1;
		end else begin
			valid_o <= load_i;
			if (load_i) begin
				hundreds_o <= `ASCII_ZERO | {4'h0, bcd[11:8]};
				tens_o     <= `ASCII_ZERO | {4'h0, bcd[7:4]};
				ones_o     <= `ASCII_ZERO | {4'h0, bcd[3:0]};
				len_o      <= next_len;
			end
		end
	end

endmodule // decimal_response

// ==== verilog/status_byte_service_request.sv ====
// status byte, service request enable and event register sets
`timescale 1ns/1ps
`include "srq_defs.svh"

module status_byte_service_request
	import srq_pkg::*;
(
	input  wire logic                   CLK_I,
	input  wire logic                   RST_I,
	input  wire logic [`REG_W-1:0]      STD_EVENT_SET_I,
	input  wire logic [`REG_W-1:0]      OPER_COND_I,
	input  wire logic                   MAV_I,
	input  wire logic                   CMD_VALID_I,
	input  wire logic [`CMD_CODE_W-1:0] CMD_CODE_I,
	input  wire logic [`REG_W-1:0]      CMD_DATA_I,
	input  wire logic                   SPOLL_I,
	output logic                        CMD_IGNORED_O,
	output logic                        RESP_VALID_O,
	output logic [`REG_W-1:0]           RESP_VALUE_O,
	output logic [7:0]                  RESP_HUNDREDS_O,
	output logic [7:0]                  RESP_TENS_O,
	output logic [7:0]                  RESP_ONES_O,
	output logic [1:0]                  RESP_LEN_O,
	output logic                        SPOLL_VALID_O,
	output logic [`REG_W-1:0]           SPOLL_BYTE_O,
	output logic [`REG_W-1:0]           STATUS_BYTE_O,
	output logic [`REG_W-1:0]           SERVICE_MASK_O,
	output logic                        SRQ_O
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// a register set summary: any event bit that its enable lets through
	function automatic logic summary(input logic [`REG_W-1:0] ev, input logic [`REG_W-1:0] en);
		return |(ev & en);
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [`REG_W-1:0] std_event;
	logic [`REG_W-1:0] std_enable;
	logic [`REG_W-1:0] oper_event;
	logic [`REG_W-1:0] oper_enable;
	logic [`REG_W-1:0] oper_cond_prev;
	logic [`REG_W-1:0] service_request_mask;
	logic              mss_prev;
	logic              rqs;

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	wire cmd_e code = cmd_e'(CMD_CODE_I);

	wire logic q_stb       = CMD_VALID_I && (code == CMD_STB_QUERY);
	wire logic w_sre       = CMD_VALID_I && (code == CMD_SRE_WRITE);
	wire logic q_sre       = CMD_VALID_I && (code == CMD_SRE_QUERY);
	wire logic q_std_ev    = CMD_VALID_I && (code == CMD_STD_EV_QUERY);
	wire logic w_std_en    = CMD_VALID_I && (code == CMD_STD_EN_WRITE);
	wire logic q_std_en    = CMD_VALID_I && (code == CMD_STD_EN_QUERY);
	wire logic q_oper_ev   = CMD_VALID_I && (code == CMD_OPER_EV_QUERY);
	wire logic w_oper_en   = CMD_VALID_I && (code == CMD_OPER_EN_WRITE);
	wire logic q_oper_en   = CMD_VALID_I && (code == CMD_OPER_EN_QUERY);
	wire logic q_oper_cond = CMD_VALID_I && (code == CMD_OPER_COND_QRY);
	wire logic do_cls      = CMD_VALID_I && (code == CMD_CLEAR_STATUS);

	wire logic any_query = q_stb | q_sre | q_std_ev | q_std_en | q_oper_ev | q_oper_en | q_oper_cond;
	wire logic any_known = any_query | w_sre | w_std_en | w_oper_en | do_cls;
	// writes aimed at read-only registers and unknown codes change nothing
	wire logic ignored   = CMD_VALID_I && !any_known;

	// ---------------------------------------------------------------
	// operation condition and transition capture
	// ---------------------------------------------------------------
	// condition is the live input itself, nothing here can clear it
	wire logic [`REG_W-1:0] oper_cond = OPER_COND_I & `OPER_EVENT_USED;
	wire logic [`REG_W-1:0] oper_rise = oper_cond & ~oper_cond_prev;

	// ---------------------------------------------------------------
	// event register next values
	// ---------------------------------------------------------------
	// a new event in the clearing cycle survives: set wins over clear
	wire logic clr_std  = q_std_ev | do_cls;
	wire logic clr_oper = q_oper_ev | do_cls;

	wire logic [`REG_W-1:0] std_set  = STD_EVENT_SET_I & `STD_EVENT_USED;
	wire logic [`REG_W-1:0] next_std_event  = (clr_std ? `REG_RESET : std_event) | std_set;
	wire logic [`REG_W-1:0] next_oper_event = (clr_oper ? `REG_RESET : oper_event) | oper_rise;

	// ---------------------------------------------------------------
	// enable register next values
	// ---------------------------------------------------------------
	// a write of zero is an ordinary write and so clears the register
	wire logic [`REG_W-1:0] next_std_enable  = w_std_en ? CMD_DATA_I : std_enable;
	wire logic [`REG_W-1:0] next_oper_enable = w_oper_en ? CMD_DATA_I : oper_enable;
	wire logic [`REG_W-1:0] next_service_mask =
		w_sre ? (CMD_DATA_I & `SRE_USED) : service_request_mask;

	// ---------------------------------------------------------------
	// status byte and master summary
	// ---------------------------------------------------------------
	wire logic std_summary  = summary(std_event, std_enable);
	wire logic oper_summary = summary(oper_event, oper_enable);

	logic [`REG_W-1:0] summary_bits;
	always_comb begin
		summary_bits = `REG_RESET;
		summary_bits[`SB_OPER_BIT] = oper_summary;
		summary_bits[`SB_STD_BIT]  = std_summary;
		summary_bits[`SB_MAV_BIT]  = MAV_I;
	end

	wire logic mss = |(summary_bits & service_request_mask);

	logic [`REG_W-1:0] summary_status_byte;
	always_comb begin
		summary_status_byte = summary_bits;
		summary_status_byte[`SB_MSS_BIT] = mss;
	end

	// ---------------------------------------------------------------
	// request service
	// ---------------------------------------------------------------
	// edge of master summary sets it, a poll clears it, the edge wins a tie
	wire logic mss_rise = mss && !mss_prev;
	wire logic next_rqs = mss_rise | (rqs & ~SPOLL_I);

	// poll answer shows the request function in bit 6, not the summary
	logic [`REG_W-1:0] poll_byte;
	always_comb begin
		poll_byte = summary_bits;
		poll_byte[`SB_MSS_BIT] = rqs;
	end

	// ---------------------------------------------------------------
	// query answer selection
	// ---------------------------------------------------------------
	// every answer is the value before this cycle's clears take effect
	wire logic [`REG_W-1:0] query_value =
		q_stb       ? summary_status_byte :
		q_sre       ? service_request_mask :
		q_std_ev    ? std_event :
		q_std_en    ? std_enable :
		q_oper_ev   ? oper_event :
		q_oper_en   ? oper_enable :
		q_oper_cond ? oper_cond :
		`REG_RESET;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			std_event            <= `REG_RESET;
			oper_event           <= `REG_RESET;
			std_enable           <= `REG_RESET;
			oper_enable          <= `REG_RESET;
			service_request_mask <= `REG_RESET;
			oper_cond_prev       <= `REG_RESET;
		end else begin
			std_event            <= next_std_event;
			oper_event           <= next_oper_event;
			std_enable           <= next_std_enable;
			oper_enable          <= next_oper_enable;
			service_request_mask <= next_service_mask;
			oper_cond_prev       <= oper_cond;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			mss_prev <= 1'b0;
			rqs      <= 1'b0;
		end else begin
			mss_prev <= mss;
			rqs      <= next_rqs;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			RESP_VALID_O  <= 1'b0;
			RESP_VALUE_O  <= `REG_RESET;
			CMD_IGNORED_O <= 1'b0;
		end else begin
			RESP_VALID_O  <= any_query;
			CMD_IGNORED_O <= ignored;
			if (any_query)
				RESP_VALUE_O <= query_value;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			SPOLL_VALID_O <= 1'b0;
			SPOLL_BYTE_O  <= `REG_RESET;
		end else begin
			SPOLL_VALID_O <= SPOLL_I;
			if (SPOLL_I)
				SPOLL_BYTE_O <= poll_byte;
		end
	end

	// mirrors lag the live status by one cycle; queries see it live
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			STATUS_BYTE_O  <= `REG_RESET;
			SERVICE_MASK_O <= `REG_RESET;
		end else begin
			STATUS_BYTE_O  <= summary_status_byte;
			SERVICE_MASK_O <= service_request_mask;
		end
	end

	assign SRQ_O = rqs;

	// ---------------------------------------------------------------
	// decimal answer text
	// ---------------------------------------------------------------
	// the controller sends already-parsed binary values; answers go back
	// as decimal digits of the weighted sum
	decimal_response u_decimal (
		.clk_i      (CLK_I),
		.rst_i      (RST_I),
		.load_i     (any_query),
		.value_i    (query_value),
		.valid_o    (),
		.hundreds_o (RESP_HUNDREDS_O),
		.tens_o     (RESP_TENS_O),
		.ones_o     (RESP_ONES_O),
		.len_o      (RESP_LEN_O)
	);

endmodule // status_byte_service_request
